// ==== src/stce_pkg.sv ====
// Package of constants and carrier types for the sequence timer and counter elements.
package stce_pkg;

    // Value ranges shared by both element kinds.
    localparam logic [15:0] STCE_VAL_MAX = 16'd32000;
    localparam logic [9:0]  STCE_NUM_MIN = 10'd1;
    localparam logic [9:0]  STCE_NUM_MAX = 10'd999;

    // Time base: the 0.01 s prescaler is derived from the clock period.
    localparam int          STCE_CLK_PERIOD_NS = 8;
    localparam int          STCE_BASE_TICK_NS  = 10_000_000;
    localparam int          STCE_BASE_TICK_CYC = STCE_BASE_TICK_NS / STCE_CLK_PERIOD_NS;

    // Base ticks per count for each unit code (0.01 s, 0.1 s, 1 s, 1 min).
    localparam logic [12:0] STCE_DIV_U1 = 13'd1;
    localparam logic [12:0] STCE_DIV_U2 = 13'd10;
    localparam logic [12:0] STCE_DIV_U3 = 13'd100;
    localparam logic [12:0] STCE_DIV_U4 = 13'd6000;
    localparam logic [2:0]  STCE_UNIT_MIN = 3'd1;
    localparam logic [2:0]  STCE_UNIT_MAX = 3'd4;

    // Register byte offsets.
    localparam logic [7:0]  STCE_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  STCE_TMR_NUM_OFS  = 8'h04;
    localparam logic [7:0]  STCE_TMR_SET_OFS  = 8'h08;
    localparam logic [7:0]  STCE_TMR_PRE_OFS  = 8'h0c;
    localparam logic [7:0]  STCE_TMR_UNIT_OFS = 8'h10;
    localparam logic [7:0]  STCE_CNT_NUM_OFS  = 8'h14;
    localparam logic [7:0]  STCE_CNT_SET_OFS  = 8'h18;
    localparam logic [7:0]  STCE_CNT_PRE_OFS  = 8'h1c;
    localparam logic [7:0]  STCE_TMR_STAT_OFS = 8'h20;
    localparam logic [7:0]  STCE_TMR_PV_OFS   = 8'h24;
    localparam logic [7:0]  STCE_TMR_REM_OFS  = 8'h28;
    localparam logic [7:0]  STCE_CNT_STAT_OFS = 8'h2c;
    localparam logic [7:0]  STCE_CNT_PV_OFS   = 8'h30;
    localparam logic [7:0]  STCE_CNT_REM_OFS  = 8'h34;

    // Control register bit positions.
    localparam int          STCE_CTRL_RESTART = 0;
    localparam int          STCE_CTRL_PAUSE   = 1;
    localparam int          STCE_CTRL_RUN     = 2;
    localparam int          STCE_CTRL_CLEAR   = 3;

    // Values after reset.
    localparam logic [9:0]  STCE_TMR_NUM_RST  = 10'd1;
    localparam logic [9:0]  STCE_CNT_NUM_RST  = 10'd2;
    localparam logic [15:0] STCE_SET_RST      = 16'd0;
    localparam logic [15:0] STCE_PRE_RST      = 16'd0;
    localparam logic [2:0]  STCE_UNIT_RST     = 3'd1;

    // Timer states.
    typedef enum logic [1:0] {
        STCE_T_IDLE  = 2'b00,
        STCE_T_RUN   = 2'b01,
        STCE_T_PAUSE = 2'b10,
        STCE_T_DONE  = 2'b11
    } stce_tstate_t;

    // Status flags of one element; the counter leaves paused low.
    typedef struct packed {
        logic paused;
        logic stopped;
        logic running;
        logic prealarm_flag;
        logic done_flag;
    } stce_flags_t;

    // Flags after reset: only stopped is set.
    localparam stce_flags_t STCE_FLAGS_RST = 5'h08;

    // Present and remaining values of one element.
    typedef struct packed {
        logic [15:0] present_value;
        logic [15:0] remaining_value;
    } stce_data_t;

endpackage : stce_pkg

// ==== src/stce_tbase.sv ====
// Time base of the timer element: one tick per count of the selected unit.
module stce_tbase
    import stce_pkg::*;
#(
    parameter int BASE_CYC = STCE_BASE_TICK_CYC
) (
    // Clock, reset and enable.
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Control.
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [2:0] unit,
    // Tick out.
    output logic            tick
);

    logic [20:0] pre_reg;
    logic [12:0] div_reg;
    logic [12:0] div_max;
    logic        base_hit;

    // Unit code to base ticks per count.
    always_comb begin
        case (unit)
            3'd1:    div_max = STCE_DIV_U1;
            3'd2:    div_max = STCE_DIV_U2;
            3'd3:    div_max = STCE_DIV_U3;
            3'd4:    div_max = STCE_DIV_U4;
            default: div_max = STCE_DIV_U1;
        endcase
    end

    assign base_hit = (pre_reg == 21'(BASE_CYC - 1));
    assign tick     = run && base_hit && (div_reg == div_max - 13'd1);

    // Prescaler to 0.01 s; it holds while paused so a pause loses no fraction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 21'h0;
        end else if (ce) begin
            if (clear) begin
                pre_reg <= 21'h0;
            end else if (run) begin
                pre_reg <= base_hit ? 21'h0 : pre_reg + 21'h1;
            end
        end
    end

    // Unit divider over the 0.01 s ticks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 13'h0;
        end else if (ce) begin
            if (clear) begin
                div_reg <= 13'h0;
            end else if (run && base_hit) begin
                div_reg <= tick ? 13'h0 : div_reg + 13'h1;
            end
        end
    end

endmodule : stce_tbase

// ==== src/stce_top.sv ====
// One timer element and one counter element for a sequence table, reached over APB.
module stce_top
    import stce_pkg::*;
#(
    parameter int BASE_CYC = STCE_BASE_TICK_CYC
) (
    // Clock, reset and enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Counter count events.
    input  wire logic        count_event,
    // Element status towards the sequence conditions.
    output stce_flags_t      tmr_flags,
    output stce_data_t       tmr_data,
    output stce_flags_t      cnt_flags,
    output stce_data_t       cnt_data
);

    // Clamp a written value into the element range.
    function automatic logic [15:0] clamp_val(input logic [31:0] v);
        clamp_val = (v > {16'h0, STCE_VAL_MAX}) ? STCE_VAL_MAX : v[15:0];
    endfunction : clamp_val

    // Check that a written element number is legal and not taken by the other element.
    function automatic logic num_ok(input logic [31:0] v, input logic [9:0] other);
        num_ok = (v >= {22'h0, STCE_NUM_MIN}) && (v <= {22'h0, STCE_NUM_MAX}) && (v[9:0] != other);
    endfunction : num_ok

    logic         restart_reg, pause_reg, run_reg;
    logic         restart_req_reg, clear_req_reg;
    logic [9:0]   tmr_num_reg, cnt_num_reg;
    logic [15:0]  tmr_set_reg, tmr_pre_reg, cnt_set_reg, cnt_pre_reg;
    logic [2:0]   unit_reg;
    logic [31:0]  prdata_reg;
    stce_tstate_t t_state_reg, t_state_next;
    logic [15:0]  t_pv_reg, t_pv_next, c_pv_reg, c_pv_next;
    logic         tick, acc, wr, bad_wr, mapped;
    stce_flags_t  tmr_flags_reg, cnt_flags_reg;
    logic [15:0]  t_rem_reg, c_rem_reg;

    // Zero-wait bus; a low enable stretches the access, but a read whose setup phase sees it low returns the old prdata_reg.
    assign acc    = psel && penable;
    assign wr     = acc && pwrite && ce && !bad_wr;
    assign pready = ce;

    // Address map and refused writes: bad numbers, bad unit codes, read-only words.
    always_comb begin
        mapped = (paddr[1:0] == 2'b00) && (paddr <= STCE_CNT_REM_OFS);
        bad_wr = 1'b0;
        if (!mapped) begin
            bad_wr = 1'b1;
        end else if (pwrite) begin
            case (paddr)
                STCE_TMR_NUM_OFS:  bad_wr = !num_ok(pwdata, cnt_num_reg);
                STCE_CNT_NUM_OFS:  bad_wr = !num_ok(pwdata, tmr_num_reg);
                STCE_TMR_UNIT_OFS: bad_wr = (pwdata < 32'(STCE_UNIT_MIN)) || (pwdata > 32'(STCE_UNIT_MAX));
                default:           bad_wr = (paddr >= STCE_TMR_STAT_OFS);
            endcase
        end
    end
    assign pslverr = acc && bad_wr;
    assign prdata  = prdata_reg;

    // Read data is captured in the setup phase so it comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (ce && psel && !penable && !pwrite) begin
            case (paddr)
                STCE_CTRL_OFS:     prdata_reg <= {29'h0, run_reg, pause_reg, restart_reg};
                STCE_TMR_NUM_OFS:  prdata_reg <= {22'h0, tmr_num_reg};
                STCE_TMR_SET_OFS:  prdata_reg <= {16'h0, tmr_set_reg};
                STCE_TMR_PRE_OFS:  prdata_reg <= {16'h0, tmr_pre_reg};
                STCE_TMR_UNIT_OFS: prdata_reg <= {29'h0, unit_reg};
                STCE_CNT_NUM_OFS:  prdata_reg <= {22'h0, cnt_num_reg};
                STCE_CNT_SET_OFS:  prdata_reg <= {16'h0, cnt_set_reg};
                STCE_CNT_PRE_OFS:  prdata_reg <= {16'h0, cnt_pre_reg};
                STCE_TMR_STAT_OFS: prdata_reg <= {27'h0, tmr_flags_reg};
                STCE_TMR_PV_OFS:   prdata_reg <= {16'h0, t_pv_reg};
                STCE_TMR_REM_OFS:  prdata_reg <= {16'h0, t_rem_reg};
                STCE_CNT_STAT_OFS: prdata_reg <= {27'h0, cnt_flags_reg};
                STCE_CNT_PV_OFS:   prdata_reg <= {16'h0, c_pv_reg};
                STCE_CNT_REM_OFS:  prdata_reg <= {16'h0, c_rem_reg};
                default:           prdata_reg <= 32'h0;
            endcase
        end
    end

    // Control bits; raising restart or setting clear posts a one-cycle request.
    // Restart acts only on a rising restart bit, so pause and resume writes keep the elapsed time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_reg     <= 1'b0;
            pause_reg       <= 1'b0;
            run_reg         <= 1'b0;
            restart_req_reg <= 1'b0;
            clear_req_reg   <= 1'b0;
        end else if (ce) begin
            restart_req_reg <= wr && (paddr == STCE_CTRL_OFS) && pwdata[STCE_CTRL_RESTART] && !restart_reg;
            clear_req_reg   <= wr && (paddr == STCE_CTRL_OFS) && pwdata[STCE_CTRL_CLEAR];
            if (wr && paddr == STCE_CTRL_OFS) begin
                restart_reg <= pwdata[STCE_CTRL_RESTART];
                pause_reg   <= pwdata[STCE_CTRL_PAUSE];
                run_reg     <= pwdata[STCE_CTRL_RUN];
            end
        end
    end

    // Element configuration; set and prealarm values above the range are clamped to it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_num_reg <= STCE_TMR_NUM_RST;
            cnt_num_reg <= STCE_CNT_NUM_RST;
            tmr_set_reg <= STCE_SET_RST;
            tmr_pre_reg <= STCE_PRE_RST;
            cnt_set_reg <= STCE_SET_RST;
            cnt_pre_reg <= STCE_PRE_RST;
            unit_reg    <= STCE_UNIT_RST;
        end else if (ce && wr) begin
            case (paddr)
                STCE_TMR_NUM_OFS:  tmr_num_reg <= pwdata[9:0];
                STCE_CNT_NUM_OFS:  cnt_num_reg <= pwdata[9:0];
                STCE_TMR_SET_OFS:  tmr_set_reg <= clamp_val(pwdata);
                STCE_TMR_PRE_OFS:  tmr_pre_reg <= clamp_val(pwdata);
                STCE_CNT_SET_OFS:  cnt_set_reg <= clamp_val(pwdata);
                STCE_CNT_PRE_OFS:  cnt_pre_reg <= clamp_val(pwdata);
                STCE_TMR_UNIT_OFS: unit_reg    <= pwdata[2:0];
                default:           unit_reg    <= unit_reg;
            endcase
        end
    end

    // The time base restarts with the timer so the first count is a full unit.
    stce_tbase #(
        .BASE_CYC (BASE_CYC)
    ) u_tbase (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .clear    (!restart_reg || restart_req_reg),
        .run      ((t_state_reg == STCE_T_RUN) && !pause_reg),
        .unit     (unit_reg),
        .tick     (tick)
    );

    // Timer next state: reset while restart is low, stop and hold at the set value.
    always_comb begin
        t_state_next = t_state_reg;
        t_pv_next    = t_pv_reg;
        if (!restart_reg) begin
            t_state_next = STCE_T_IDLE;
            t_pv_next    = 16'h0;
        end else begin
            if (restart_req_reg) begin
                t_pv_next = 16'h0;
            end else if (t_state_reg == STCE_T_RUN && tick) begin
                t_pv_next = t_pv_reg + 16'h1;
            end
            case (1'b1)
                (t_pv_next >= tmr_set_reg): begin
                    t_state_next = STCE_T_DONE;
                    t_pv_next    = tmr_set_reg;
                end
                pause_reg: t_state_next = STCE_T_PAUSE;
                default:   t_state_next = STCE_T_RUN;
            endcase
        end
    end

    // Timer state, value and registered status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_state_reg   <= STCE_T_IDLE;
            t_pv_reg      <= 16'h0;
            t_rem_reg     <= STCE_SET_RST;
            tmr_flags_reg <= STCE_FLAGS_RST;
        end else if (ce) begin
            t_state_reg                 <= t_state_next;
            t_pv_reg                    <= t_pv_next;
            t_rem_reg                   <= tmr_set_reg - t_pv_next;
            tmr_flags_reg.done_flag     <= (t_state_next == STCE_T_DONE);
            tmr_flags_reg.prealarm_flag <= restart_reg && (t_pv_next >= tmr_pre_reg);
            tmr_flags_reg.running       <= (t_state_next == STCE_T_RUN);
            tmr_flags_reg.stopped       <= (t_state_next == STCE_T_IDLE);
            tmr_flags_reg.paused        <= (t_state_next == STCE_T_PAUSE);
        end
    end

    // Counter next value: clear request first, then one per event up to the ceiling.
    always_comb begin
        c_pv_next = c_pv_reg;
        if (clear_req_reg) begin
            c_pv_next = 16'h0;
        end else if (run_reg && count_event && c_pv_reg < STCE_VAL_MAX) begin
            c_pv_next = c_pv_reg + 16'h1;
        end
    end

    // Counter value and registered status; done does not stop the count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_pv_reg      <= 16'h0;
            c_rem_reg     <= STCE_SET_RST;
            cnt_flags_reg <= STCE_FLAGS_RST;
        end else if (ce) begin
            c_pv_reg                    <= c_pv_next;
            c_rem_reg                   <= (c_pv_next >= cnt_set_reg) ? 16'h0 : cnt_set_reg - c_pv_next;
            cnt_flags_reg.done_flag     <= (c_pv_next >= cnt_set_reg);
            cnt_flags_reg.prealarm_flag <= (c_pv_next >= cnt_pre_reg);
            cnt_flags_reg.running       <= run_reg;
            cnt_flags_reg.stopped       <= !run_reg;
            cnt_flags_reg.paused        <= 1'b0;
        end
    end

    assign tmr_flags = tmr_flags_reg;
    assign cnt_flags = cnt_flags_reg;
    assign tmr_data  = '{present_value: t_pv_reg, remaining_value: t_rem_reg};
    assign cnt_data  = '{present_value: c_pv_reg, remaining_value: c_rem_reg};

    // Checks on the element behaviour.
    property p_restart_zero;
        @(posedge pclk) disable iff (!presetn)
        (ce && restart_req_reg && restart_reg) |=> (t_pv_reg == 16'h0 || t_pv_reg == tmr_set_reg);
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("timer not restarted from zero");

    property p_tmr_pre;
        @(posedge pclk) disable iff (!presetn)
        (ce && restart_reg && t_pv_next >= tmr_pre_reg) |=> tmr_flags.prealarm_flag;
    endproperty
    a_tmr_pre: assert property (p_tmr_pre) else $error("timer prealarm missing");

    property p_tmr_done_hold;
        @(posedge pclk) disable iff (!presetn)
        ce ##1 tmr_flags.done_flag |-> (t_pv_reg == $past(tmr_set_reg) && t_rem_reg == 16'h0);
    endproperty
    a_tmr_done_hold: assert property (p_tmr_done_hold) else $error("finished timer not held");

    property p_tmr_off;
        @(posedge pclk) disable iff (!presetn)
        (ce && !restart_reg) |=> (t_pv_reg == 16'h0 && tmr_flags.stopped && !tmr_flags.done_flag);
    endproperty
    a_tmr_off: assert property (p_tmr_off) else $error("timer not reset");

    property p_tmr_pause;
        @(posedge pclk) disable iff (!presetn)
        (tmr_flags.paused && pause_reg && restart_reg && !restart_req_reg) ##1 ce |-> $stable(t_pv_reg);
    endproperty
    a_tmr_pause: assert property (p_tmr_pause) else $error("paused timer moved");

    property p_tmr_range;
        @(posedge pclk) disable iff (!presetn)
        ce |=> (t_pv_reg <= STCE_VAL_MAX) && (t_rem_reg <= STCE_VAL_MAX)
            && (t_pv_reg + t_rem_reg == $past(tmr_set_reg));
    endproperty
    a_tmr_range: assert property (p_tmr_range) else $error("timer value out of range");

    property p_cnt_step;
        @(posedge pclk) disable iff (!presetn)
        (ce && run_reg && count_event && !clear_req_reg && c_pv_reg < STCE_VAL_MAX)
            |=> (c_pv_reg == $past(c_pv_reg) + 16'h1);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter missed an event");

    property p_cnt_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && !run_reg && !clear_req_reg) |=> $stable(c_pv_reg);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("stopped counter moved");

    property p_cnt_flags;
        @(posedge pclk) disable iff (!presetn)
        ce |=> (cnt_flags.done_flag == (c_pv_reg >= $past(cnt_set_reg)))
            && (cnt_flags.prealarm_flag == (c_pv_reg >= $past(cnt_pre_reg)));
    endproperty
    a_cnt_flags: assert property (p_cnt_flags) else $error("counter flags wrong");

    property p_num_unique;
        @(posedge pclk) disable iff (!presetn)
        (tmr_num_reg != cnt_num_reg) && (tmr_num_reg <= STCE_NUM_MAX) && (cnt_num_reg >= STCE_NUM_MIN);
    endproperty
    a_num_unique: assert property (p_num_unique) else $error("element numbers clash");

endmodule : stce_top

// ==== tb/stce_seq_model.sv ====
// Sequence-side model that issues bursts of count events toward the counter element.
module stce_seq_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Burst request from the bench.
    input  wire logic       go,
    input  wire logic [7:0] burst,
    // Count events and status.
    output logic            count_event,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_reg;
    // One event every other cycle, so each event is a clean single-cycle pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_reg    <= 8'h00;
            count_event <= 1'b0;
        end else if (go) begin
            left_reg <= burst;
        end else begin
            count_event <= !count_event && left_reg != 8'h00;
            if (!count_event && left_reg != 8'h00) left_reg <= left_reg - 8'h01;
        end
    end
    assign busy = left_reg != 8'h00 || count_event;
endmodule : stce_seq_model

// ==== tb/stce_top_bench.sv ====
// Self-checking bench for the timer and counter elements.
module stce_top_bench;
    import stce_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, ce, psel, penable, pwrite, go, count_event, busy;
    logic [7:0] paddr, burst;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    stce_flags_t tmr_flags, cnt_flags;
    stce_data_t  tmr_data, cnt_data;
    int err_count = 0;
    int cmp_count = 0;
    // Small prescaler keeps every unit short enough to simulate.
    stce_top #(.BASE_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_event(count_event), .tmr_flags(tmr_flags), .tmr_data(tmr_data), .cnt_flags(cnt_flags),
        .cnt_data(cnt_data));
    stce_seq_model model (.pclk(pclk), .presetn(presetn), .go(go), .burst(burst), .count_event(count_event),
        .busy(busy));
    // Clock generation.
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready without assuming a wait count.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk({31'h0, e}, {31'h0, ee});
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, ee});
    endtask : rd
    // Counts cycles until the timer finishes; gives up after a bound.
    task wait_done(output int n);
        n = 0;
        while (tmr_flags.done_flag !== 1'b1 && n < 30000) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_done
    task t_reset;
        rd(STCE_TMR_NUM_OFS, 32'h1, 1'b0);
        rd(STCE_CNT_NUM_OFS, 32'h2, 1'b0);
        rd(STCE_TMR_STAT_OFS, 32'h8, 1'b0);
        rd(8'h38, 32'h0, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task t_refuse;
        wr(STCE_TMR_UNIT_OFS, 32'h5, 1'b1);
        wr(STCE_TMR_NUM_OFS, 32'h2, 1'b1);
        wr(STCE_CNT_NUM_OFS, 32'h3e8, 1'b1);
        wr(STCE_TMR_NUM_OFS, 32'h3e7, 1'b0);
        wr(STCE_TMR_PV_OFS, 32'h1, 1'b1);
        wr(STCE_TMR_SET_OFS, 32'h9c40, 1'b0);
        rd(STCE_TMR_SET_OFS, 32'h7d00, 1'b0);
        $display("test refusals done");
    endtask : t_refuse
    task t_timer;
        int n;
        logic [15:0] pv;
        wr(STCE_TMR_SET_OFS, 32'h5, 1'b0);
        wr(STCE_TMR_PRE_OFS, 32'h3, 1'b0);
        wr(STCE_CTRL_OFS, 32'h1, 1'b0);
        n = 0;
        while (tmr_flags.prealarm_flag !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk({16'h0, tmr_data.present_value}, 32'h3);
        chk({31'h0, tmr_flags.running}, 32'h1);
        wr(STCE_CTRL_OFS, 32'h3, 1'b0);
        repeat (3) @(posedge pclk);
        pv = tmr_data.present_value;
        repeat (40) @(posedge pclk);
        chk({16'h0, tmr_data.present_value}, {16'h0, pv});
        chk({31'h0, pv != 16'h0}, 32'h1);
        chk({31'h0, tmr_flags.paused}, 32'h1);
        wr(STCE_CTRL_OFS, 32'h1, 1'b0);
        wait_done(n);
        chk({31'h0, n <= 12}, 32'h1);
        repeat (30) @(posedge pclk);
        chk(tmr_data, {16'h5, 16'h0});
        wr(STCE_CTRL_OFS, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        chk({27'h0, tmr_flags}, 32'h8);
        chk({16'h0, tmr_data.present_value}, 32'h0);
        // One count per unit: 4, 40, 400 and 24000 cycles with the small prescaler.
        wr(STCE_TMR_SET_OFS, 32'h1, 1'b0);
        for (int u = 1; u <= 4; u++) begin
            wr(STCE_TMR_UNIT_OFS, u, 1'b0);
            wr(STCE_CTRL_OFS, 32'h0, 1'b0);
            wr(STCE_CTRL_OFS, 32'h1, 1'b0);
            wait_done(n);
            chk({31'h0, n >= 4 * (u == 1 ? 1 : u == 2 ? 10 : u == 3 ? 100 : 6000) - 1}, 32'h1);
            chk({31'h0, n <= 4 * (u == 1 ? 1 : u == 2 ? 10 : u == 3 ? 100 : 6000) + 4}, 32'h1);
        end
        $display("test timer done");
    endtask : t_timer
    task send(input logic [7:0] k);
        @(posedge pclk);
        go <= 1'b1; burst <= k;
        @(posedge pclk);
        go <= 1'b0;
        do @(posedge pclk); while (busy === 1'b1);
        repeat (3) @(posedge pclk);
    endtask : send
    task t_counter;
        wr(STCE_CNT_SET_OFS, 32'h3, 1'b0);
        wr(STCE_CNT_PRE_OFS, 32'h2, 1'b0);
        wr(STCE_CTRL_OFS, 32'h4, 1'b0);
        send(8'h2);
        chk({27'h0, cnt_flags} & 32'h3, 32'h2);
        send(8'h3);
        chk(cnt_data, {16'h5, 16'h0});
        chk({31'h0, cnt_flags.done_flag}, 32'h1);
        wr(STCE_CTRL_OFS, 32'h0, 1'b0);
        send(8'h3);
        chk({16'h0, cnt_data.present_value}, 32'h5);
        rd(STCE_CNT_PV_OFS, 32'h5, 1'b0);
        wr(STCE_CTRL_OFS, 32'h8, 1'b0);
        repeat (3) @(posedge pclk);
        chk({16'h0, cnt_data.present_value}, 32'h0);
        // A low clock enable must freeze the counter even while events arrive.
        wr(STCE_CTRL_OFS, 32'h4, 1'b0);
        ce <= 1'b0;
        send(8'h3);
        ce <= 1'b1;
        chk({16'h0, cnt_data.present_value}, 32'h0);
        $display("test counter done");
    endtask : t_counter
    task results;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // Watchdog: the full run needs about 25000 cycles.
    initial begin
        #(8 * 80000);
        err_count++;
        results();
    end
    // Main sequence.
    initial begin
        presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; go = 1'b0; burst = 8'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_refuse();
        t_timer();
        t_counter();
        results();
    end
endmodule : stce_top_bench
